// *** src/fifo_status_event_irq_defines.svh ***
`ifndef FIFO_STATUS_EVENT_IRQ_DEFINES_SVH
`define FIFO_STATUS_EVENT_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register word indices on the control port
// ----------------------------------------------------------------------
`define OFS_OCCUPANCY_COUNT 3'h0
`define OFS_LIVE_FLAGS 3'h1
`define OFS_STICKY_EVENTS 3'h2
`define OFS_IRQ_MASK 3'h3
`define OFS_HIGH_WATER_THRESHOLD 3'h4
`define OFS_LOW_WATER_THRESHOLD 3'h5

// ----------------------------------------------------------------------
// Field positions, shared by live flags, sticky events and mask
// ----------------------------------------------------------------------
`define BIT_FULL 0
`define BIT_DRAINED 1
`define BIT_HIGH_WATER 2
`define BIT_LOW_WATER 3
`define BIT_OVERRUN 4
`define BIT_UNDERRUN 5
`define BIT_MASK_ALL 6
`define FLAG_WIDTH 6
`define MASK_WIDTH 7
`define DATA_WIDTH 32

// ----------------------------------------------------------------------
// Reset values and threshold limits
// ----------------------------------------------------------------------
`define STICKY_RESET 6'h00
`define LIVE_RESET 6'h00
`define MASK_RESET 7'h00
`define THRESH_MIN 1
`define HIGH_WATER_MARGIN_DUAL 4
`define HIGH_WATER_MARGIN_SINGLE 1
`define DEFAULT_DEPTH 16

`endif

// *** src/fifo_status_event_irq_pkg.sv ***
`include "fifo_status_event_irq_defines.svh"

package fifo_status_event_irq_pkg;

    // ------------------------------------------------------------------
    // Types shared by the register file and the event bank
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        IDX_OCCUPANCY = 3'b000,
        IDX_LIVE = 3'b001,
        IDX_STICKY = 3'b010,
        IDX_MASK = 3'b011,
        IDX_HIGH_WATER = 3'b100,
        IDX_LOW_WATER = 3'b101
    } reg_index_e;

    typedef logic [`FLAG_WIDTH-1:0] flag_t;
    typedef logic [`MASK_WIDTH-1:0] mask_t;
    typedef logic [`DATA_WIDTH-1:0] word_t;

endpackage

// *** src/sticky_event_bank.sv ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------------
// Bank of sticky bits, one per condition
// ----------------------------------------------------------------------
module sticky_event_bank
    import fifo_status_event_irq_pkg::*;
#(
    parameter int unsigned WIDTH = `FLAG_WIDTH
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] setVec,
    input wire logic [WIDTH-1:0] clearVec,
    output logic [WIDTH-1:0] stickyQ,
    output logic [WIDTH-1:0] risingQ
);

    genvar i;

    // Two flops per condition, sticky and rising; a set arriving with a clear wins
    // so an event in the clearing cycle is never lost
    generate
        for (i = 0; i < WIDTH; i = i + 1)
        begin : g_bit
            always_ff @(posedge clock or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    stickyQ[i] <= 1'b0;
                    risingQ[i] <= 1'b0;
                end
                else
                begin
                    if (setVec[i])
                        stickyQ[i] <= 1'b1;
                    else if (clearVec[i])
                        stickyQ[i] <= 1'b0;
                    // Marks the zero to one transition of this bit
                    risingQ[i] <= setVec[i] & ~stickyQ[i];
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

// *** src/fifo_status_event_irq.sv ***

`timescale 1ns/100ps
`default_nettype none

module fifo_status_event_irq
    import fifo_status_event_irq_pkg::*;
#(
    parameter int unsigned DEPTH = `DEFAULT_DEPTH,
    parameter bit DUAL_CLOCK = 1'b0,
    parameter bit ALLOW_BACKPRESSURE = 1'b0,
    parameter int unsigned LEVEL_W = $clog2(DEPTH + 1)
)
(
    input wire logic clock,
    input wire logic rst_b,
    // Control port of the processor host
    input wire logic [2:0] regAddress,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [`DATA_WIDTH-1:0] regWriteData,
    output logic [`DATA_WIDTH-1:0] regReadData,
    output logic regReadValid,
    // Observation of the FIFO storage
    input wire logic [LEVEL_W-1:0] fillLevel,
    input wire logic writeAttempt,
    input wire logic readAttempt,
    // Flags and interrupt towards the system
    output logic [`FLAG_WIDTH-1:0] liveFlags,
    output logic irq
);

    // ------------------------------------------------------------------
    // Constants derived from the build options
    // ------------------------------------------------------------------
    // Dual-clock storage needs a deeper margin for its pointer latency
    // Thresholds are kept at level width; wider writes are clamped first
    localparam int unsigned HW_MARGIN = DUAL_CLOCK ? `HIGH_WATER_MARGIN_DUAL
                                                   : `HIGH_WATER_MARGIN_SINGLE;
    localparam logic [LEVEL_W-1:0] HIGH_WATER_MAX = LEVEL_W'(DEPTH - HW_MARGIN);
    localparam logic [LEVEL_W-1:0] THRESH_FLOOR = LEVEL_W'(`THRESH_MIN);
    localparam logic [LEVEL_W-1:0] FULL_LEVEL = LEVEL_W'(DEPTH);
    localparam logic [LEVEL_W-1:0] EMPTY_LEVEL = '0;
    localparam word_t THRESH_MIN_WORD = `DATA_WIDTH'(`THRESH_MIN);
    localparam word_t HIGH_WATER_MAX_WORD = `DATA_WIDTH'(DEPTH - HW_MARGIN);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [LEVEL_W-1:0] highWaterQ;
    logic [LEVEL_W-1:0] lowWaterQ;
    mask_t maskQ;
    flag_t liveD;
    flag_t liveQ;
    flag_t stickyQ;
    flag_t stickyRise;
    flag_t clearVec;
    flag_t effMask;
    flag_t pendingD;
    logic irqQ;
    logic [`DATA_WIDTH-1:0] readDataQ;
    logic readValidQ;
    logic isFull;
    logic isDrained;
    logic writeHit;
    logic wrSticky;
    logic wrMask;
    logic wrHighWater;
    logic wrLowWater;
    reg_index_e regIndex;

    // Bus address taken as a register index
    assign regIndex = reg_index_e'(regAddress);

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // One enable per writable register; the level and live flag
    // indices are read-only and the unmapped ones decode to nothing,
    // so writes there are dropped without a trace
    always_comb
    begin
        wrSticky = 1'b0;
        wrMask = 1'b0;
        wrHighWater = 1'b0;
        wrLowWater = 1'b0;
        if (regWrite)
        begin
            case (regIndex)
                IDX_STICKY:
                    wrSticky = 1'b1;
                IDX_MASK:
                    wrMask = 1'b1;
                IDX_HIGH_WATER:
                    wrHighWater = 1'b1;
                IDX_LOW_WATER:
                    wrLowWater = 1'b1;
                default:
                    wrSticky = 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Threshold clamp
    // ------------------------------------------------------------------
    // Clamping keeps the comparators meaningful: a zero threshold would
    // make the low-water flag mirror the drained flag only
    function automatic logic [LEVEL_W-1:0] clampThreshold(
        input word_t value
    );
        logic [LEVEL_W-1:0] result;
        result = THRESH_FLOOR;
        if (value < THRESH_MIN_WORD)
            result = THRESH_FLOOR;
        else if (value > HIGH_WATER_MAX_WORD)
            result = HIGH_WATER_MAX;
        else
            result = value[LEVEL_W-1:0];
        return result;
    endfunction

    // ------------------------------------------------------------------
    // Live condition decode
    // ------------------------------------------------------------------
    // Capacity and emptiness straight from the reported fill level
    assign isFull = (fillLevel == FULL_LEVEL);
    assign isDrained = (fillLevel == EMPTY_LEVEL);

    // Next value of the live flags, one bit per condition
    always_comb
    begin
        liveD = `LIVE_RESET;
        liveD[`BIT_FULL] = isFull;
        liveD[`BIT_DRAINED] = isDrained;
        liveD[`BIT_HIGH_WATER] = (fillLevel >= highWaterQ);
        liveD[`BIT_LOW_WATER] = (fillLevel <= lowWaterQ);
        // With backpressure the storage refuses such accesses itself,
        // so the pulses are suppressed rather than reported falsely;
        // the strobes are taken raw, one pulse per attempting cycle,
        // and back-to-back attempts give back-to-back pulses
        if (!ALLOW_BACKPRESSURE)
        begin
            liveD[`BIT_OVERRUN] = writeAttempt & isFull;
            liveD[`BIT_UNDERRUN] = readAttempt & isDrained;
        end
    end

    // Live flags registered; overrun and underrun last one cycle each
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            liveQ <= `LIVE_RESET;
        else
            liveQ <= liveD;
    end

    // ------------------------------------------------------------------
    // Sticky event bank
    // ------------------------------------------------------------------
    // A write of one clears only the addressed positions; set beats
    // clear inside the bank, so a condition that persists survives
    // the write of one
    assign writeHit = wrSticky;
    assign clearVec = writeHit ? regWriteData[`FLAG_WIDTH-1:0] : '0;

    // Sets from the same next value that loads the live flags, so both
    // registers change on the same edge
    sticky_event_bank #(
        .WIDTH(`FLAG_WIDTH)
    ) u_sticky (
        .clock(clock),
        .rst_b(rst_b),
        .setVec(liveD),
        .clearVec(clearVec),
        .stickyQ(stickyQ),
        .risingQ(stickyRise)
    );

    // ------------------------------------------------------------------
    // Interrupt mask register
    // ------------------------------------------------------------------
    // Cleared at reset so nothing interrupts before software opts in
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            maskQ <= `MASK_RESET;
        else if (wrMask)
            maskQ <= regWriteData[`MASK_WIDTH-1:0];
    end

    // Effective per-condition enables; the global bit covers all six
    assign effMask = maskQ[`FLAG_WIDTH-1:0]
                   | {`FLAG_WIDTH{maskQ[`BIT_MASK_ALL]}};

    // ------------------------------------------------------------------
    // Interrupt request
    // ------------------------------------------------------------------
    // Pending while an enabled sticky bit is set; a set bit that rose
    // under an enabled mask holds the request only while still enabled
    assign pendingD = stickyQ & effMask;

    // Registered request; level stays high until software clears the
    // sticky bit or drops its enable
    // Trade-off: a level is easier to share than a pulse, but an
    // unserviced event keeps the line up
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            irqQ <= 1'b0;
        else
            irqQ <= |(pendingD | (stickyRise & effMask));
    end

    // ------------------------------------------------------------------
    // Threshold registers
    // ------------------------------------------------------------------
    // High-water threshold starts at the largest allowed value
    // Both marks share one clamp, so neither can pass that value
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            highWaterQ <= HIGH_WATER_MAX;
        else if (wrHighWater)
            highWaterQ <= clampThreshold(regWriteData);
    end

    // Low-water threshold starts at the floor value
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            lowWaterQ <= THRESH_FLOOR;
        else if (wrLowWater)
            lowWaterQ <= clampThreshold(regWriteData);
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Read data registered one cycle after the request; unmapped
    // indices read as zero so software never sees stale data
    // Each register is narrower than a word, so its upper bits read
    // as zero; the data then hold until the next read
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            readDataQ <= '0;
            readValidQ <= 1'b0;
        end
        else
        begin
            readValidQ <= regRead;
            if (regRead)
            begin
                case (regIndex)
                    IDX_OCCUPANCY:
                        readDataQ <= `DATA_WIDTH'(fillLevel);
                    IDX_LIVE:
                        readDataQ <= `DATA_WIDTH'(liveQ);
                    IDX_STICKY:
                        readDataQ <= `DATA_WIDTH'(stickyQ);
                    IDX_MASK:
                        readDataQ <= `DATA_WIDTH'(maskQ);
                    IDX_HIGH_WATER:
                        readDataQ <= `DATA_WIDTH'(highWaterQ);
                    IDX_LOW_WATER:
                        readDataQ <= `DATA_WIDTH'(lowWaterQ);
                    default:
                        readDataQ <= '0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------------
    assign regReadData = readDataQ;
    assign regReadValid = readValidQ;
    assign liveFlags = liveQ;
    assign irq = irqQ;

endmodule

`default_nettype wire

// *** sim/fifo_status_event_irq_checker.sv ***
`timescale 1ns/100ps
`default_nettype none

// --------
// Port checks of the flag block
// --------
module fifo_status_event_irq_checker
    import fifo_status_event_irq_pkg::*;
#(
    parameter int unsigned DEPTH = 16,
    parameter bit ALLOW_BACKPRESSURE = 1'b0,
    parameter int unsigned LEVEL_W = 5
)
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [2:0] regAddress,
    input wire logic regRead,
    input wire logic regWrite,
    input wire logic [31:0] regWriteData,
    input wire logic [31:0] regReadData,
    input wire logic regReadValid,
    input wire logic [LEVEL_W-1:0] fillLevel,
    input wire logic writeAttempt,
    input wire logic readAttempt,
    input wire logic [5:0] liveFlags,
    input wire logic irq
);
    logic maskTouched_q;

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // Until the mask is written no source may interrupt
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
            maskTouched_q <= 1'b0;
        else if (regWrite && regAddress == 3'h3)
            maskTouched_q <= 1'b1;
    end

    full_flag_a: assert property ($past(rst_b) |-> liveFlags[0] == ($past(fillLevel) == DEPTH))
        else $error("full flag wrong");
    drained_flag_a: assert property ($past(rst_b) |-> liveFlags[1] == ($past(fillLevel) == 0))
        else $error("drained flag wrong");
    overrun_pulse_a: assert property ($past(rst_b) |-> liveFlags[4] ==
        (!ALLOW_BACKPRESSURE && $past(writeAttempt) && $past(fillLevel) == DEPTH))
        else $error("overrun flag wrong");
    underrun_pulse_a: assert property ($past(rst_b) |-> liveFlags[5] ==
        (!ALLOW_BACKPRESSURE && $past(readAttempt) && $past(fillLevel) == 0))
        else $error("underrun flag wrong");
    read_answer_a: assert property ($past(rst_b) |-> regReadValid == $past(regRead))
        else $error("read answer timing wrong");
    occupancy_read_a: assert property (regRead && regAddress == 3'h0 |=>
        regReadData == 32'($past(fillLevel))) else $error("occupancy read wrong");
    unmapped_read_a: assert property (regRead && regAddress > 3'h5 |=> regReadData == 32'h0)
        else $error("unmapped read not zero");
    irq_quiet_a: assert property (!maskTouched_q |-> !irq)
        else $error("interrupt before any enable");

    cover property (liveFlags[4]);
    cover property (liveFlags[5]);
    cover property ($rose(irq));
endmodule

`default_nettype wire

// *** sim/ctrl_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none

// --------
// Processor host on the control port
// --------
module ctrl_host_model
    import fifo_status_event_irq_pkg::*;
(
    input wire logic clock,
    output logic [2:0] regAddress,
    output logic regRead,
    output logic regWrite,
    output word_t regWriteData,
    input wire word_t regReadData,
    input wire logic regReadValid
);
    // Idle bus shows a changed pattern, never a stale value
    initial
    begin
        regAddress = 3'h7;
        regRead = 1'b0;
        regWrite = 1'b0;
        regWriteData = 32'h0;
    end

    // Writing ones clears sticky bits; zeros leave them
    task automatic wr(input logic [2:0] a, input word_t d);
        @(posedge clock);
        #2;
        regAddress = a;
        regWriteData = d;
        regWrite = 1'b1;
        @(posedge clock);
        #2;
        regWrite = 1'b0;
        regAddress = ~a;
        regWriteData = ~d;
    endtask

    // Answer is due exactly one cycle after the read edge
    task automatic rd(input logic [2:0] a, output word_t d);
        @(posedge clock);
        #2;
        regAddress = a;
        regRead = 1'b1;
        @(posedge clock);
        #2;
        regRead = 1'b0;
        regAddress = ~a;
        d = (regReadValid === 1'b1) ? regReadData : 'x;
    endtask
endmodule

`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/100ps
`default_nettype none

// --------
// Top of the bench
// --------
module tb
    import fifo_status_event_irq_pkg::*;
;
    logic clock, rst_b, regRead, regWrite, regReadValid, writeAttempt, readAttempt, irq, armed;
    logic [2:0] regAddress;
    logic [4:0] fillLevel, hw, lw;
    word_t regWriteData, regReadData, seen, rngState, dualReadData;
    flag_t liveFlags, expLive, expSticky, dualFlags;
    int n_fail, n_checks;
    logic [2:0] clAddr [6] = '{3'h4, 3'h4, 3'h5, 3'h5, 3'h4, 3'h5};
    word_t clVal [6] = '{32'h0, 32'h64, 32'h64, 32'h0, 32'hC, 32'h3};
    word_t clExp [6] = '{32'h1, 32'hF, 32'hF, 32'h1, 32'hC, 32'h3};
    logic [4:0] trigFill [7] = '{5'h10, 5'h00, 5'hC, 5'h3, 5'h10, 5'h00, 5'h00};
    logic [6:0] trigWr = 7'h10;
    logic [6:0] trigRd = 7'h60;

    fifo_status_event_irq #(.DEPTH(16)) i_fifo_status_event_irq (.clock(clock), .rst_b(rst_b),
        .regAddress(regAddress), .regRead(regRead), .regWrite(regWrite),
        .regWriteData(regWriteData), .regReadData(regReadData), .regReadValid(regReadValid),
        .fillLevel(fillLevel), .writeAttempt(writeAttempt), .readAttempt(readAttempt),
        .liveFlags(liveFlags), .irq(irq));
    // Second build: dual-clock margin and backpressure allowed, same stimulus
    fifo_status_event_irq #(.DEPTH(16), .DUAL_CLOCK(1'b1), .ALLOW_BACKPRESSURE(1'b1))
        i_fifo_status_event_irq_dual (.clock(clock), .rst_b(rst_b), .regAddress(regAddress),
        .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData),
        .regReadData(dualReadData), .regReadValid(), .fillLevel(fillLevel),
        .writeAttempt(writeAttempt), .readAttempt(readAttempt), .liveFlags(dualFlags), .irq());
    ctrl_host_model i_ctrl_host_model (.clock(clock), .regAddress(regAddress),
        .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData),
        .regReadData(regReadData), .regReadValid(regReadValid));

    function automatic word_t xorshift(input word_t s);
        word_t x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    // Flags the block should show one edge after these inputs
    function automatic flag_t expect_flags(input logic [4:0] f, input logic w, input logic r);
        return {r && f == 5'h00, w && f == 5'h10, f <= lw, f >= hw, f == 5'h00, f == 5'h10};
    endfunction

    task automatic check(input string what, input word_t s, input word_t e);
        n_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask

    task automatic test_done();
        if (n_fail == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Checks the previous cycle's flags, then drives the next inputs
    task automatic step(input logic [4:0] f, input logic w, input logic r);
        @(posedge clock);
        #2;
        if (armed)
        begin
            check("live flags", 32'(liveFlags), 32'(expLive));
            check("dual flags", 32'(dualFlags), 32'(expLive & 6'h0F));
        end
        armed = 1'b1;
        fillLevel = f;
        writeAttempt = w;
        readAttempt = r;
        expLive = expect_flags(f, w, r);
        expSticky = expSticky | expLive;
    endtask

    // Free-running clock
    initial
    begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Hang guard, far beyond the expected run length
    initial
    begin
        #200000;
        n_fail++;
        test_done();
    end

    // Main sequence
    initial
    begin
        {n_fail, n_checks} = '0;
        {armed, writeAttempt, readAttempt, fillLevel, rst_b} = '0;
        rngState = 32'h44;
        hw = 5'hF;
        lw = 5'h1;
        repeat (3) @(posedge clock);
        #2;
        rst_b = 1'b1;
        expSticky = expect_flags(5'h00, 1'b0, 1'b0);
        i_ctrl_host_model.rd(3'h3, seen);
        check("mask", seen, 32'h0);
        i_ctrl_host_model.rd(3'h4, seen);
        check("high water", seen, 32'hF);
        check("dual high water", dualReadData, 32'hC);
        i_ctrl_host_model.rd(3'h2, seen);
        check("sticky", seen, 32'(expSticky));
        for (int k = 0; k < 6; k++)
        begin
            i_ctrl_host_model.wr(clAddr[k], clVal[k]);
            i_ctrl_host_model.rd(clAddr[k], seen);
            check("threshold", seen, clExp[k]);
            check("dual threshold", dualReadData, (clExp[k] > 32'hC) ? 32'hC : clExp[k]);
        end
        hw = 5'hC;
        lw = 5'h3;
        i_ctrl_host_model.wr(3'h1, 32'hFFFFFFFF);
        i_ctrl_host_model.rd(3'h1, seen);
        check("live read", seen, 32'(expect_flags(5'h00, 1'b0, 1'b0)));
        i_ctrl_host_model.wr(3'h2, 32'h3F);
        i_ctrl_host_model.rd(3'h2, seen);
        check("sticky set wins", seen, 32'(expSticky));
        i_ctrl_host_model.rd(3'h7, seen);
        check("unmapped", seen, 32'h0);
        step(5'h10, 1'b1, 1'b0);
        step(5'h00, 1'b0, 1'b1);
        step(5'h00, 1'b0, 1'b1);
        repeat (300)
        begin
            rngState = xorshift(rngState);
            step(5'(rngState[7:0] % 17), rngState[8], rngState[9]);
        end
        step(5'h08, 1'b0, 1'b0);
        i_ctrl_host_model.rd(3'h0, seen);
        check("occupancy", seen, 32'h8);
        i_ctrl_host_model.wr(3'h2, 32'h0);
        i_ctrl_host_model.rd(3'h2, seen);
        check("sticky kept", seen, 32'(expSticky));
        i_ctrl_host_model.wr(3'h2, 32'h3F);
        i_ctrl_host_model.rd(3'h2, seen);
        check("sticky cleared", seen, 32'h0);
        for (int b = 0; b < 7; b++)
        begin
            i_ctrl_host_model.wr(3'h3, 32'h1 << b);
            i_ctrl_host_model.rd(3'h3, seen);
            check("mask", seen, 32'h1 << b);
            step(trigFill[b], trigWr[b], trigRd[b]);
            step(5'h08, 1'b0, 1'b0);
            step(5'h08, 1'b0, 1'b0);
            check("irq raised", 32'(irq), 32'h1);
            i_ctrl_host_model.wr(3'h2, 32'h3F);
            step(5'h08, 1'b0, 1'b0);
            check("irq dropped", 32'(irq), 32'h0);
        end
        // A reset in mid-run drops enables and events set just before it
        step(5'h10, 1'b1, 1'b0);
        step(5'h08, 1'b0, 1'b0);
        @(posedge clock);
        #2;
        rst_b = 1'b0;
        @(posedge clock);
        #2;
        rst_b = 1'b1;
        i_ctrl_host_model.rd(3'h3, seen);
        check("mask after reset", seen, 32'h0);
        i_ctrl_host_model.rd(3'h2, seen);
        check("sticky after reset", seen, 32'h0);
        check("irq after reset", 32'(irq), 32'h0);
        test_done();
    end
endmodule

bind fifo_status_event_irq fifo_status_event_irq_checker #(.DEPTH(DEPTH), .LEVEL_W(LEVEL_W),
    .ALLOW_BACKPRESSURE(ALLOW_BACKPRESSURE))
    i_checker (.clock(clock), .rst_b(rst_b), .regAddress(regAddress), .regRead(regRead),
    .regWrite(regWrite), .regWriteData(regWriteData), .regReadData(regReadData),
    .regReadValid(regReadValid), .fillLevel(fillLevel), .writeAttempt(writeAttempt),
    .readAttempt(readAttempt), .liveFlags(liveFlags), .irq(irq));

`default_nettype wire
